// *** nvac_ctrl.sv ***
// Self-access controller for the byte data EEPROM and the 14-bit program flash.
// Assumes a core that issues at most one special-register access per clock,
// with mem-side arrays held in this module; all inputs are synchronous.
module nvac_ctrl
  import nvac_pkg::*;
#(
  parameter int EE_DEPTH     = 64,                 // Data EEPROM bytes
  parameter int FLASH_DEPTH  = 2048,               // Program flash words
  parameter int EE_WR_CYCLES = EE_WRITE_CYCLES,    // Shorten for simulation
  parameter int FL_WR_CYCLES = FLASH_PROG_CYCLES   // Shorten for simulation
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        abort_reset,     // Reset cause that may interrupt a write
  input  wire logic        reg_wr,          // Core writes a register this cycle
  input  wire logic        reg_rd,          // Core reads a register this cycle
  input  wire logic [2:0]  reg_sel,         // Register select
  input  wire logic [7:0]  reg_wdata,       // Write data from the core
  input  wire logic        flash_update_permit,  // Flash write config bit
  input  wire logic        prot_full,       // Full protection flag; overrides partial, does not block flash writes
  input  wire logic        prot_partial,    // Part of flash code protected
  input  wire logic [10:0] prot_boundary,   // First protected word when partial
  input  wire logic        update_done_clear,    // Software clears the done flag
  output logic [7:0]       reg_rdata,       // Read data back to the core
  output logic             core_stall,      // Holds instruction execution
  output logic             update_done_flag // Write complete flag
);
  // ------------------------------------------------------------------
  // Storage and registers
  // ------------------------------------------------------------------
  logic [7:0]  ee_mem [EE_DEPTH];           // Data EEPROM array
  logic [13:0] fl_mem [FLASH_DEPTH];        // Program flash array
  logic [7:0]  data_low_ff;                 // mem_data_low
  logic [5:0]  data_high_ff;                // mem_data_high, 6 bits used
  logic [7:0]  addr_low_ff;                 // mem_addr_low
  logic [4:0]  addr_high_ff;                // mem_addr_high, 5 bits used
  logic        space_ff;                    // space_select
  logic        permit_ff;                   // update_permit_bit
  logic        abort_err_ff;                // abort_error_flag
  logic        rd_start_ff;                 // Read start bit
  logic        wr_start_ff;                 // Write start bit
  logic        wr_space_ff;                 // Space captured at write start
  nvac_state_t state_ff;                    // Controller state
  nvac_key_t   key_ff;                      // Unlock tracker
  logic [31:0] cnt_ff;                      // Cycle counter for timed phases

  // Decoded accesses
  logic ctl_wr;
  logic key_wr;
  logic start_wr;
  logic flash_ok;
  logic [12:0] full_addr;
  assign ctl_wr    = reg_wr && (reg_sel == SEL_CONTROL);
  assign key_wr    = reg_wr && (reg_sel == SEL_KEY);
  assign full_addr = {addr_high_ff, addr_low_ff};
  // Write start accepted only after full key and earlier permit
  assign start_wr  = ctl_wr && reg_wdata[BIT_WRITE_START] && permit_ff
                     && (key_ff == NVAC_KEY_TWO) && (state_ff == NVAC_IDLE);
  // Flash writes gated by config and partial protection
  assign flash_ok  = flash_update_permit &&
                     (!prot_partial || prot_full || (full_addr[10:0] < prot_boundary));

  // ------------------------------------------------------------------
  // Unlock tracker
  // ------------------------------------------------------------------
  // Any access other than the next expected step restarts it
  always_ff @(posedge clock) begin
    if (rst) begin
      key_ff <= NVAC_KEY_NONE;
    end else if (key_wr && reg_wdata == KEY_FIRST && key_ff == NVAC_KEY_NONE) begin
      key_ff <= NVAC_KEY_ONE;
    end else if (key_wr && reg_wdata == KEY_SECOND && key_ff == NVAC_KEY_ONE) begin
      key_ff <= NVAC_KEY_TWO;
    end else if (reg_wr || reg_rd) begin
      key_ff <= NVAC_KEY_NONE;          // Start write or stray access ends the key
    end
  end

  // ------------------------------------------------------------------
  // Control bits
  // ------------------------------------------------------------------
  // Permit changes only by software writes and by reset
  always_ff @(posedge clock) begin
    if (rst) begin
      permit_ff <= 1'b0;
    end else if (ctl_wr) begin
      permit_ff <= reg_wdata[BIT_PERMIT];
    end
  end

  // Space select kept across resets of the write abort kind
  always_ff @(posedge clock) begin
    if (ctl_wr && state_ff == NVAC_IDLE) begin
      space_ff <= reg_wdata[BIT_SPACE];
    end
  end

  // Abort error set when a reset hits a running write
  always_ff @(posedge clock) begin
    if (abort_reset && state_ff == NVAC_WRITE) begin
      abort_err_ff <= 1'b1;
    end else if (rst) begin
      abort_err_ff <= 1'b0;
    end else if (ctl_wr) begin
      abort_err_ff <= reg_wdata[BIT_ABORT_ERR];
    end
  end

  // ------------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------------
  // Start bits set only by software, cleared by hardware at end
  always_ff @(posedge clock) begin
    if (rst) begin
      state_ff    <= NVAC_IDLE;
      rd_start_ff <= 1'b0;
      wr_start_ff <= 1'b0;
      wr_space_ff <= 1'b0;
      cnt_ff      <= 32'h0;
    end else begin
      unique case (state_ff)
        NVAC_IDLE: begin
          if (start_wr) begin
            // Flash write blocked by protection leaves start bit clear
            if (!reg_wdata[BIT_SPACE] || flash_ok) begin
              wr_start_ff <= 1'b1;
              wr_space_ff <= reg_wdata[BIT_SPACE];
              state_ff    <= NVAC_WRITE;
              cnt_ff      <= 32'h0;
            end
          end else if (ctl_wr && reg_wdata[BIT_READ_START] && reg_wdata[BIT_SPACE]) begin
            // Flash read fetches during the next two cycles
            rd_start_ff <= 1'b1;
            state_ff    <= NVAC_READ;
            cnt_ff      <= 32'h0;
          end
        end
        NVAC_READ: begin
          if (cnt_ff == 32'(FLASH_READ_SLOTS - 1)) begin
            rd_start_ff <= 1'b0;
            state_ff    <= NVAC_IDLE;
          end else begin
            cnt_ff <= cnt_ff + 32'h1;
          end
        end
        NVAC_WRITE: begin
          // Runs to the end whatever the permit bit does
          if (cnt_ff == 32'(wr_space_ff ? FL_WR_CYCLES - 1 : EE_WR_CYCLES - 1)) begin
            state_ff <= NVAC_DONE;
          end else begin
            cnt_ff <= cnt_ff + 32'h1;
          end
        end
        NVAC_DONE: begin
          // Clear start bit together with the done flag set
          wr_start_ff <= 1'b0;
          state_ff    <= NVAC_IDLE;
        end
      endcase
    end
  end

  // Done flag: set wins over software clear
  always_ff @(posedge clock) begin
    if (rst) begin
      update_done_flag <= 1'b0;
    end else if (state_ff == NVAC_DONE) begin
      update_done_flag <= 1'b1;
    end else if (update_done_clear) begin
      update_done_flag <= 1'b0;
    end
  end

  // Core stall: flash read slots and flash write time
  // Only instruction issue halts; clock and peripherals keep running
  always_ff @(posedge clock) begin
    if (rst) begin
      core_stall <= 1'b0;
    end else if (state_ff == NVAC_IDLE) begin
      core_stall <= (start_wr && reg_wdata[BIT_SPACE] && flash_ok)
                    || (ctl_wr && !start_wr && reg_wdata[BIT_READ_START]
                        && reg_wdata[BIT_SPACE]);
    end else if (state_ff == NVAC_READ) begin
      core_stall <= (cnt_ff != 32'(FLASH_READ_SLOTS - 1));
    end else if (state_ff == NVAC_WRITE) begin
      // Held until the word lands, so the core resumes with the done flag
      core_stall <= wr_space_ff;
    end else begin
      core_stall <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Address and data registers, kept across abort resets
  // ------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reg_wr && reg_sel == SEL_ADDR_LOW) begin
      addr_low_ff <= reg_wdata;
    end
    if (reg_wr && reg_sel == SEL_ADDR_HIGH) begin
      addr_high_ff <= reg_wdata[4:0];
    end
  end

  // Data holds until a read lands or software writes it
  always_ff @(posedge clock) begin
    if (ctl_wr && reg_wdata[BIT_READ_START] && !reg_wdata[BIT_SPACE]
        && state_ff == NVAC_IDLE && !start_wr) begin
      data_low_ff <= ee_mem[addr_low_ff[5:0]];         // Ready next cycle
    end else if (state_ff == NVAC_READ && cnt_ff == 32'(FLASH_READ_SLOTS - 1)) begin
      data_low_ff  <= fl_mem[full_addr[10:0]][7:0];    // Visible after slots
      data_high_ff <= fl_mem[full_addr[10:0]][13:8];
    end else if (reg_wr && reg_sel == SEL_DATA_LOW) begin
      data_low_ff <= reg_wdata;
    end else if (reg_wr && reg_sel == SEL_DATA_HIGH) begin
      data_high_ff <= reg_wdata[5:0];
    end
  end

  // Array update at end of the write time
  always_ff @(posedge clock) begin
    if (state_ff == NVAC_DONE) begin
      if (wr_space_ff) begin
        fl_mem[full_addr[10:0]] <= {data_high_ff, data_low_ff};
      end else begin
        ee_mem[addr_low_ff[5:0]] <= data_low_ff;
      end
    end
  end

  // ------------------------------------------------------------------
  // Read-back mux, registered
  // ------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      reg_rdata <= RST_BYTE;
    end else begin
      unique case (reg_sel)
        SEL_CONTROL:   reg_rdata <= {space_ff, 3'h0, abort_err_ff, permit_ff,
                                     wr_start_ff, rd_start_ff};
        SEL_DATA_LOW:  reg_rdata <= data_low_ff;
        SEL_DATA_HIGH: reg_rdata <= {2'h0, data_high_ff};
        SEL_ADDR_LOW:  reg_rdata <= addr_low_ff;
        SEL_ADDR_HIGH: reg_rdata <= {3'h0, addr_high_ff};
        default:       reg_rdata <= RST_BYTE;   // Key port reads zero
      endcase
    end
  end
endmodule

// *** nvac_pkg.sv ***
// Constants for the nonvolatile self-access controller.
// Assumes one core clock of 25 MHz; all times become cycle counts here.
package nvac_pkg;
  // ------------------------------------------------------------------
  // Register select codes on the core's special-register port
  // ------------------------------------------------------------------
  localparam logic [2:0] SEL_CONTROL   = 3'h0;  // mem_access_control
  localparam logic [2:0] SEL_KEY       = 3'h1;  // unlock_key_port
  localparam logic [2:0] SEL_DATA_LOW  = 3'h2;  // mem_data_low
  localparam logic [2:0] SEL_DATA_HIGH = 3'h3;  // mem_data_high
  localparam logic [2:0] SEL_ADDR_LOW  = 3'h4;  // mem_addr_low
  localparam logic [2:0] SEL_ADDR_HIGH = 3'h5;  // mem_addr_high
  // ------------------------------------------------------------------
  // Control register field positions
  // ------------------------------------------------------------------
  localparam int BIT_READ_START  = 0;
  localparam int BIT_WRITE_START = 1;
  localparam int BIT_PERMIT      = 2;
  localparam int BIT_ABORT_ERR   = 3;
  localparam int BIT_SPACE       = 7;
  // ------------------------------------------------------------------
  // Unlock keys and reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;
  localparam logic [7:0] RST_BYTE   = 8'h00;
  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLOCK_HZ            = 25000000;
  localparam int EE_WRITE_TIME_US    = 4000;   // Data EEPROM write time
  localparam int FLASH_PROG_TIME_US  = 2000;   // flash_program_time
  localparam int EE_WRITE_CYCLES     = EE_WRITE_TIME_US * (CLOCK_HZ / 1000000);
  localparam int FLASH_PROG_CYCLES   = FLASH_PROG_TIME_US * (CLOCK_HZ / 1000000);
  localparam int FLASH_READ_SLOTS    = 2;      // Cycles spent fetching a flash word
  // ------------------------------------------------------------------
  // Controller states, Gray along idle -> read -> write -> done
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    NVAC_IDLE  = 2'b00,
    NVAC_READ  = 2'b01,
    NVAC_WRITE = 2'b11,
    NVAC_DONE  = 2'b10
  } nvac_state_t;
  // Unlock tracker steps
  typedef enum logic [1:0] {
    NVAC_KEY_NONE = 2'b00,
    NVAC_KEY_ONE  = 2'b01,
    NVAC_KEY_TWO  = 2'b11
  } nvac_key_t;
endpackage

// *** nvac_checker.sv ***
// Assertions for the self-access controller, bound to its top module.
// Assumes a write start is only issued while no write is running.
module nvac_checker
  import nvac_pkg::*;
#(
  parameter int EE_WR_CYCLES = 8,
  parameter int FL_WR_CYCLES = 8
) (
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [2:0] reg_sel,
  input wire logic [7:0] reg_wdata,
  input wire logic       flash_update_permit,
  input wire logic       prot_partial,
  input wire logic       update_done_clear,
  input wire logic       core_stall,
  input wire logic       update_done_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int EE_MAX = EE_WR_CYCLES + 3;  // Latest edge for the done flag
  localparam int FL_MAX = FL_WR_CYCLES + 2;  // Longest flash write stall
  logic [1:0]  key_ff;   // Keys seen in order
  logic        perm_ff;  // Shadow of the permit bit
  logic [15:0] cnt_ff;   // Cycles of the current stall
  logic        ctl;      // Control write
  logic        k1;       // First key
  logic        k2;       // Second key
  logic        go;       // Start that must be taken
  assign ctl = reg_wr && reg_sel == SEL_CONTROL;
  assign k1  = reg_wr && reg_sel == SEL_KEY && reg_wdata == KEY_FIRST;
  assign k2  = reg_wr && reg_sel == SEL_KEY && reg_wdata == KEY_SECOND;
  assign go  = ctl && reg_wdata[BIT_WRITE_START] && key_ff == 2'h2 && perm_ff && !core_stall;
  // ------------------------------------------------------------
  // Shadow tracker, restarted by any other access
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      key_ff  <= 2'h0;
      perm_ff <= 1'b0;
    end else if (reg_wr || reg_rd) begin
      key_ff <= k1 ? 2'h1 : (k2 && key_ff == 2'h1) ? 2'h2 : 2'h0;
      if (ctl) begin
        perm_ff <= reg_wdata[BIT_PERMIT];
      end
    end
  end
  // Counts stall cycles
  always_ff @(posedge clock) begin
    if (rst || !core_stall) begin
      cnt_ff <= 16'h0;
    end else begin
      cnt_ff <= cnt_ff + 16'h1;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  property p_cause; $rose(core_stall) |-> $past(ctl && reg_wdata[BIT_SPACE]); endproperty
  a_cause: assert property (p_cause) else $error("stall without flash access");
  property p_read; ctl && reg_wdata[7:0] == 8'h81 && !core_stall
    |=> core_stall [*2] ##1 !core_stall; endproperty
  a_read: assert property (p_read) else $error("flash read stall not two");
  property p_refuse; ctl && reg_wdata[BIT_WRITE_START] && !core_stall
    && !(go && flash_update_permit) |=> !core_stall; endproperty
  a_refuse: assert property (p_refuse) else $error("refused start stalled");
  property p_fgo; go && reg_wdata[BIT_SPACE] && flash_update_permit && !prot_partial
    |=> core_stall; endproperty
  a_fgo: assert property (p_fgo) else $error("flash write not started");
  property p_flen; $fell(core_stall) && cnt_ff > 16'h2
    |-> cnt_ff >= FL_WR_CYCLES && cnt_ff <= FL_MAX; endproperty
  a_flen: assert property (p_flen) else $error("flash stall length");
  property p_resume; $fell(core_stall) && cnt_ff > 16'h2 |-> update_done_flag; endproperty
  a_resume: assert property (p_resume) else $error("resume without done");
  property p_sticky; update_done_flag && !update_done_clear |=> update_done_flag; endproperty
  a_sticky: assert property (p_sticky) else $error("done flag dropped");
  property p_eedone; go && !reg_wdata[BIT_SPACE] && !update_done_flag
    |-> ##[EE_WR_CYCLES:EE_MAX] $rose(update_done_flag); endproperty
  a_eedone: assert property (p_eedone) else $error("data write not done");
  c_read: cover property (ctl && reg_wdata == 8'h81);
  c_fwrite: cover property ($fell(core_stall) && cnt_ff > 16'h2);
  c_done: cover property ($rose(update_done_flag));
endmodule

bind nvac_ctrl nvac_checker #(
  .EE_WR_CYCLES(EE_WR_CYCLES),
  .FL_WR_CYCLES(FL_WR_CYCLES)
) u_checker (.clock(clock), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_sel(reg_sel),
  .reg_wdata(reg_wdata), .flash_update_permit(flash_update_permit),
  .prot_partial(prot_partial), .update_done_clear(update_done_clear),
  .core_stall(core_stall), .update_done_flag(update_done_flag));

// *** nvac_core_model.sv ***
// Core model issuing one register access per slot.
// Assumes one caller; it holds off while the core is stalled.
module nvac_core_model
  import nvac_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       core_stall,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic [2:0]      reg_sel,
  output logic [7:0]      reg_wdata,
  output logic            core_hung
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_sel   = SEL_KEY;
    reg_wdata = 8'h00;
    core_hung = 1'b0;
  end
  // One slot: wait out a stall mid-cycle, then drive at the edge
  task automatic slot(input logic w, input logic r, input logic [2:0] s,
                      input logic [7:0] d);
    int n = 0;
    @(negedge clock);
    while (core_stall !== 1'b0 && n < 400) begin  // Nothing issued while halted
      n++;
      @(negedge clock);
    end
    if (n == 400) begin
      core_hung = 1'b1;
    end
    @(posedge clock);
    reg_wr    <= w;  // Back-to-back slots, no code between
    reg_rd    <= r;
    reg_sel   <= s;
    reg_wdata <= w ? d : ~reg_wdata;  // Idle bus keeps moving
  endtask
endmodule

// *** test_eeprom_flash_self_access.sv ***
// Testbench for the self-access controller.
// Assumes the core model drives the register port.
`define CHK(what, exp, got) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
      errors++; \
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); \
    end \
  end
module test_eeprom_flash_self_access
  import nvac_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] PRE[6] = '{8'h00, 8'h00, 8'h04, 8'h04, 8'h84, 8'h84};
  localparam logic [7:0] CTL[6] = '{8'h06, 8'h02, 8'h06, 8'h06, 8'h86, 8'h86};
  localparam logic [7:0] EXP[6] = '{8'h04, 8'h00, 8'h04, 8'h04, 8'h84, 8'h84};
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        abort_reset = 1'b0;
  logic        fup = 1'b1;
  logic        pfull = 1'b0;
  logic        ppart = 1'b0;
  logic        done_clr = 1'b0;
  logic        rd_pend = 1'b0;
  logic        reg_wr, reg_rd, stall, done, hung;
  logic [2:0]  reg_sel;
  logic [7:0]  reg_wdata, rdata, exp_b;
  logic [31:0] seed = 32'h1b2b;
  logic [31:0] r;
  logic [7:0]  exp_q[$];  // Expected read bytes
  int          errors = 0;
  int          comparisons = 0;
  nvac_core_model u_core (.clock(clock), .core_stall(stall), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_sel(reg_sel), .reg_wdata(reg_wdata), .core_hung(hung));
  nvac_ctrl #(.EE_WR_CYCLES(8), .FL_WR_CYCLES(8)) dut (.clock(clock), .rst(rst),
    .abort_reset(abort_reset), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_sel(reg_sel),
    .reg_wdata(reg_wdata), .flash_update_permit(fup), .prot_full(pfull),
    .prot_partial(ppart), .prot_boundary(11'h000), .update_done_clear(done_clr),
    .reg_rdata(rdata), .core_stall(stall), .update_done_flag(done));
  initial begin
    forever #20 clock = ~clock;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Read data arrives one cycle after the read slot
  always @(posedge clock) begin
    if (rd_pend === 1'b1) begin
      exp_b = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx;
      `CHK("rdata", exp_b, rdata)
    end
    rd_pend <= reg_rd;
  end
  task automatic put(input logic [2:0] s, input logic [7:0] d);
    u_core.slot(1'b1, 1'b0, s, d);
  endtask
  task automatic get(input logic [2:0] s, input logic [7:0] e);
    exp_q.push_back(e);
    u_core.slot(1'b0, 1'b1, s, 8'h00);
  endtask
  task automatic idle();
    u_core.slot(1'b0, 1'b0, SEL_KEY, 8'h00);
  endtask
  // Permit write, key pair, optional break, then the control write and two no-op slots
  task automatic seq(input logic [7:0] pre, input logic [7:0] ka, input logic [7:0] kb,
                     input logic brk, input logic [7:0] ctl);
    put(SEL_CONTROL, pre);
    put(SEL_KEY, ka);
    if (brk) begin
      get(SEL_CONTROL, pre);
    end
    put(SEL_KEY, kb);
    put(SEL_CONTROL, ctl);
    idle();
    idle();
  endtask
  task automatic wait_done();
    int n = 0;
    while (done !== 1'b1 && n < 200) begin
      idle();
      n++;
    end
    `CHK("done", 1'b1, done)
  endtask
  task automatic end_of_test();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    r = xs();
    put(SEL_CONTROL, 8'h00);   // Space select has no reset value
    put(SEL_ADDR_HIGH, 8'h00); // Address known before the protection check
    put(SEL_ADDR_LOW, 8'h00);
    get(SEL_CONTROL, 8'h00);
    // Refused starts: permit (twice), break, order, config, protection
    for (int i = 0; i < 6; i++) begin
      fup   <= (i != 4);
      ppart <= (i == 5);
      seq(PRE[i], (i == 3) ? KEY_SECOND : KEY_FIRST, (i == 3) ? KEY_FIRST : KEY_SECOND,
          i == 2, CTL[i]);
      get(SEL_CONTROL, EXP[i]);
    end
    `CHK("done", 1'b0, done)
    fup   <= 1'b1;
    ppart <= 1'b0;
    put(SEL_ADDR_LOW, {2'h0, r[5:0]});
    put(SEL_DATA_LOW, r[15:8]);
    seq(8'h04, KEY_FIRST, KEY_SECOND, 1'b0, 8'h06);
    put(SEL_CONTROL, 8'h00);
    get(SEL_CONTROL, 8'h02);
    wait_done();
    get(SEL_CONTROL, 8'h00);
    idle();
    `CHK("done", 1'b1, done)
    done_clr <= 1'b1;
    idle();
    done_clr <= 1'b0;
    idle();
    `CHK("done", 1'b0, done)
    put(SEL_DATA_LOW, ~r[15:8]);
    put(SEL_CONTROL, 8'h01);
    get(SEL_DATA_LOW, r[15:8]);
    pfull <= 1'b1;
    put(SEL_ADDR_LOW, r[23:16]);
    put(SEL_ADDR_HIGH, {5'h0, r[26:24]});
    put(SEL_DATA_LOW, r[7:0]);
    put(SEL_DATA_HIGH, r[31:24]);
    seq(8'h84, KEY_FIRST, KEY_SECOND, 1'b0, 8'h86);
    wait_done();
    get(SEL_CONTROL, 8'h84);
    put(SEL_DATA_LOW, ~r[7:0]);
    put(SEL_DATA_HIGH, 8'h00);
    put(SEL_CONTROL, 8'h81);
    idle();
    idle();
    get(SEL_DATA_LOW, r[7:0]);
    get(SEL_DATA_HIGH, {2'h0, r[29:24]});
    // Reset cuts a data write short
    put(SEL_ADDR_LOW, {2'h0, r[5:0]});
    seq(8'h04, KEY_FIRST, KEY_SECOND, 1'b0, 8'h06);
    rst <= 1'b1;
    abort_reset <= 1'b1;
    idle();
    rst <= 1'b0;
    abort_reset <= 1'b0;
    get(SEL_CONTROL, 8'h08);
    get(SEL_ADDR_LOW, {2'h0, r[5:0]});
    repeat (3) idle();  // Let the last read leave the queue
    `CHK("core hung", 1'b0, hung)
    `CHK("queue left", 0, exp_q.size())
    end_of_test();
  end
endmodule
